/* File: ssw_pkg.sv */
// Shared constants and types for the serial-controlled 16-channel low-side switch core.
// Assumes a 50 MHz core clock; only the over-voltage filter time is derived from that rate.
package ssw_pkg;

   localparam int          SSW_WORD_W     = 24;
   localparam int          SSW_CH_N       = 16;
   localparam int          SSW_CMD_HI     = 23;
   localparam int          SSW_CMD_LO     = 18;
   localparam int          SSW_OV_RETRY_B = 16;
   localparam int          SSW_TH_RETRY_B = 17;
   localparam int          SSW_ANY_FLT_B  = 23;
   localparam int          SSW_OV_FLT_B   = 22;
   localparam int          SSW_CLK_MHZ    = 50;
   localparam int          SSW_OV_FILT_US = 50;
   // Over-voltage must persist longer than the filter time; floor, at least one cycle
   localparam int          SSW_OV_FILT_CYC = (SSW_OV_FILT_US * SSW_CLK_MHZ < 1) ? 1 : SSW_OV_FILT_US * SSW_CLK_MHZ;
   localparam int          SSW_OV_CNT_W   = $clog2(SSW_OV_FILT_CYC + 1);

   // Command selector codes
   localparam logic [5:0]  SSW_CMD_ONOFF  = 6'h00;
   localparam logic [5:0]  SSW_CMD_OLEN   = 6'h01;
   localparam logic [5:0]  SSW_CMD_RETRY  = 6'h02;
   localparam logic [5:0]  SSW_CMD_SFPD   = 6'h03;
   localparam logic [5:0]  SSW_CMD_PWMEN  = 6'h04;
   localparam logic [5:0]  SSW_CMD_ANDOR  = 6'h05;
   localparam logic [5:0]  SSW_CMD_RESET  = 6'h06;

   // Reset values of the command registers
   localparam logic [15:0] SSW_ONOFF_RST  = 16'h0000;
   localparam logic [15:0] SSW_OLEN_RST   = 16'h0000;
   localparam logic [15:0] SSW_SFPD_RST   = 16'hFFFF;
   localparam logic [15:0] SSW_PWMEN_RST  = 16'h0000;
   localparam logic [15:0] SSW_ANDOR_RST  = 16'h0000;

   // Per-channel fault inputs from the analog stages
   typedef struct packed {
      logic [15:0] overTemp;
      logic [15:0] overCurrent;
      logic [15:0] openLoad;
   } ssw_flt_t;

   // Command registers written by frames
   typedef struct packed {
      logic [15:0] onOff;
      logic [15:0] olEn;
      logic [15:0] sfpd;
      logic [15:0] pwmEn;
      logic [15:0] andOr;
      logic        ovRetry;
      logic        thRetry;
   } ssw_cfg_t;

endpackage

/* File: ssw_spi_ctrl.sv */
// Serial control and fault reporting core of a 16-channel low-side switch.
// All pins are asynchronous to core_clk and are synchronised here; serial clock
// must stay well below core_clk/4 so every edge is seen.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Serial output driven only while chip select low, released otherwise.
// - Chip select rising applies the shifted-in word to the outputs.
// - Chip select falling loads current fault status into the shift register.
// - Serial clock and input ignored while chip select high.
// - Serial input sampled on every serial clock falling edge.
// - Next fault bit shifted onto serial output on every rising edge.
// - Input register holds one 24-bit word; frame complete after 24 bits.
// - Fault word: any-fault bit 23, over-voltage 22, zeros 21..16, outputs 15..0.
// - Each transfer swaps 24-bit command and fault words, MSB first.
// - Faults report as one, healthy outputs as zero.
// - Output field one commands on, zero commands off.
// - Low serial-output supply holds reset with all drivers off.
// - Reset pin low switches outputs off and clears registers.
// - Over-voltage beyond filter time switches all outputs off while it lasts.
// - Over-voltage recovery resumes or stays off per retry bit.
// - Over-voltage shutdown sets over-voltage and any-fault flags.
// - Over-temperature shuts only that output; retry or stay off globally.
// - Over-current limits until thermal, then thermal handling and fault bit; core reports over-current on a driven output as a fault bit at once.
// - Open load reported for commanded-off outputs only.
// - Daisy chain: 24 bits per device, data passes through, applied on rise.
// - Command bits 23..18 select command, bits 15..0 per-output settings.
// - Retry command: bit 16 over-voltage recovery, bit 17 thermal retry.
module ssw_spi_ctrl
   import ssw_pkg::*;
#(
   parameter int OV_FILT_CYC = SSW_OV_FILT_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        clkEn,
   input  wire logic        csN,
   input  wire logic        sclk,
   input  wire logic        si,
   output logic             soOut,
   output logic             soOe,
   input  wire logic        rstN,
   input  wire logic        serialOutputSupplyOk,
   input  wire logic        battOverVoltage,
   input  wire ssw_flt_t    chFault,
   output logic [15:0]      lowSideSwitchOutputs,
   output ssw_cfg_t         cfgOut,
   output logic             ovShutdown
);

   initial begin
      if (OV_FILT_CYC < 1 || OV_FILT_CYC >= (1 << SSW_OV_CNT_W)) begin
         $error("OV_FILT_CYC out of range");
      end
   end

   typedef struct packed {
      logic [2:0]                 csS;
      logic [2:0]                 sckS;
      logic [1:0]                 siS;
      logic [1:0]                 rstS;
      logic [1:0]                 supS;
      logic [1:0]                 ovS;
      ssw_flt_t                   fltS1;
      ssw_flt_t                   fltS2;
      logic [SSW_WORD_W-1:0]      sh;
      logic                       so;
      logic [4:0]                 bitCnt;
      ssw_cfg_t                   cfg;
      logic [15:0]                thermOff;
      logic [SSW_OV_CNT_W-1:0]    ovCnt;
      logic                       ovShut;
      logic                       ovFlag;
      logic [15:0]                drv;
   } ssw_state_t;

   localparam ssw_cfg_t CFG_RST = '{onOff: SSW_ONOFF_RST, olEn: SSW_OLEN_RST, sfpd: SSW_SFPD_RST,
                                   pwmEn: SSW_PWMEN_RST, andOr: SSW_ANDOR_RST, ovRetry: 1'b0, thRetry: 1'b0};

   ssw_state_t state_r;
   ssw_state_t state_nxt;

   // Assembles the fault word from live per-channel status
   function automatic logic [SSW_WORD_W-1:0] faultWord(input logic [15:0] chFlt, input logic ovF);
      logic [SSW_WORD_W-1:0] w;
      w = '0;
      w[15:0]          = chFlt;
      w[SSW_OV_FLT_B]  = ovF;
      w[SSW_ANY_FLT_B] = ovF | (|chFlt);
      return w;
   endfunction

   logic              csFall;
   logic              csRise;
   logic              sckFall;
   logic              sckRise;
   logic              csLow;
   logic              intRst;
   logic [15:0]       chFlt;
   logic [5:0]        cmdSel;
   logic [15:0]       cmdData;

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins (second and third stages only)
   assign csFall  = state_r.csS[2] & ~state_r.csS[1];
   assign csRise  = ~state_r.csS[2] & state_r.csS[1];
   assign csLow   = ~state_r.csS[1];
   assign sckFall = state_r.sckS[2] & ~state_r.sckS[1];
   assign sckRise = ~state_r.sckS[2] & state_r.sckS[1];
   assign intRst  = ~state_r.rstS[1] | ~state_r.supS[1];

   assign cmdSel  = state_r.sh[SSW_CMD_HI:SSW_CMD_LO];
   assign cmdData = state_r.sh[15:0];

   always_comb begin
      state_nxt = state_r;

      // Double-flop synchronisers; stage 0 feeds only stage 1
      state_nxt.csS   = {state_r.csS[1:0], csN};
      state_nxt.sckS  = {state_r.sckS[1:0], sclk};
      state_nxt.siS   = {state_r.siS[0], si};
      state_nxt.rstS  = {state_r.rstS[0], rstN};
      state_nxt.supS  = {state_r.supS[0], serialOutputSupplyOk};
      state_nxt.ovS   = {state_r.ovS[0], battOverVoltage};
      state_nxt.fltS1 = chFault;
      state_nxt.fltS2 = state_r.fltS1;

      // Over-current on a driven output reports as fault
      // Open load only when commanded off and detect current enabled
      chFlt = state_r.thermOff
            | (state_r.fltS2.overCurrent & state_r.drv)
            | (state_r.fltS2.openLoad & ~state_r.cfg.onOff & state_r.cfg.olEn);

      // Serial activity only counts while chip select is low
      if (csLow) begin
         // Sample input on falling serial clock
         // Old contents move on toward the serial output
         if (sckFall) begin
            state_nxt.sh = {state_r.sh[SSW_WORD_W-2:0], state_r.siS[1]};
            // Count bits up to a full word
            if (state_r.bitCnt < 5'(SSW_WORD_W)) begin
               state_nxt.bitCnt = state_r.bitCnt + 5'd1;
            end
         end
         // Present next bit on rising serial clock
         if (sckRise) begin
            state_nxt.so = state_r.sh[SSW_WORD_W-1];
         end
      end

      // Snapshot faults as the frame opens
      // Loaded only here, never refreshed mid-frame
      if (csFall) begin
         state_nxt.sh     = faultWord(chFlt, state_r.ovFlag);
         state_nxt.so     = state_nxt.sh[SSW_WORD_W-1];
         state_nxt.bitCnt = '0;
         // Reported flag is consumed; a standing shutdown sets it again below
         state_nxt.ovFlag = 1'b0;
      end

      // Apply command on chip select rising
      if (csRise && state_r.bitCnt == 5'(SSW_WORD_W)) begin
         unique case (cmdSel)
            // One is on, zero is off
            SSW_CMD_ONOFF: begin
               state_nxt.cfg.onOff = cmdData;
               // A fresh command re-arms latched thermal shutdowns
               state_nxt.thermOff  = state_r.thermOff & cmdData & state_r.fltS2.overTemp;
            end
            SSW_CMD_OLEN:  state_nxt.cfg.olEn  = cmdData;
            SSW_CMD_RETRY: begin
               state_nxt.cfg.ovRetry = state_r.sh[SSW_OV_RETRY_B];
               state_nxt.cfg.thRetry = state_r.sh[SSW_TH_RETRY_B];
            end
            SSW_CMD_SFPD:  state_nxt.cfg.sfpd  = cmdData;
            SSW_CMD_PWMEN: state_nxt.cfg.pwmEn = cmdData;
            SSW_CMD_ANDOR: state_nxt.cfg.andOr = cmdData;
            SSW_CMD_RESET: begin
               state_nxt.cfg      = CFG_RST;
               state_nxt.thermOff = '0;
            end
            default: begin
            end
         endcase
      end

      // Per-output thermal shutdown with global retry choice
      // Current-limited output reaching thermal limit lands here
      state_nxt.thermOff = state_nxt.thermOff | (state_r.fltS2.overTemp & state_r.cfg.onOff);
      if (state_r.cfg.thRetry) begin
         state_nxt.thermOff = state_nxt.thermOff & state_r.fltS2.overTemp;
      end

      if (state_r.ovS[1]) begin
         if (state_r.ovCnt < SSW_OV_CNT_W'(OV_FILT_CYC)) begin
            state_nxt.ovCnt = state_r.ovCnt + 1'b1;
         end else begin
            state_nxt.ovShut = 1'b1;
         end
      end else begin
         state_nxt.ovCnt = '0;
         if (state_r.ovShut) begin
            state_nxt.ovShut = 1'b0;
            if (!state_r.cfg.ovRetry) begin
               state_nxt.cfg.onOff = '0;
            end
         end
      end
      // Flag set wins over the capture clear
      if (state_nxt.ovShut) begin
         state_nxt.ovFlag = 1'b1;
      end

      state_nxt.drv = state_nxt.cfg.onOff & ~state_nxt.thermOff & ~{16{state_nxt.ovShut}};

      // Supply low: drivers off, registers cleared
      // Reset pin low: drivers off, registers cleared
      if (intRst) begin
         state_nxt.sh       = '0;
         state_nxt.so       = 1'b0;
         state_nxt.bitCnt   = '0;
         state_nxt.cfg      = CFG_RST;
         state_nxt.thermOff = '0;
         state_nxt.ovCnt    = '0;
         state_nxt.ovShut   = 1'b0;
         state_nxt.ovFlag   = 1'b0;
         state_nxt.drv      = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         // Pins idle: chip select high, reset released, supply good
         state_r      <= '0;
         state_r.csS  <= 3'b111;
         state_r.rstS <= 2'b11;
         state_r.supS <= 2'b11;
         state_r.cfg  <= CFG_RST;
      end else if (clkEn) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Drive serial output only during the frame
   assign soOe                 = csLow;
   assign soOut                = state_r.so;
   assign lowSideSwitchOutputs = state_r.drv;
   assign cfgOut               = state_r.cfg;
   assign ovShutdown           = state_r.ovShut;

endmodule

/* File: ssw_spi_ctrl_sva.sv */
// Port-level assertions for the serial switch core.
// Assumes the bench keeps csN high around every reset.
`timescale 1ns/1ns
module ssw_spi_ctrl_chk
   import ssw_pkg::*;
#(
   parameter int OV_FILT_CYC = SSW_OV_FILT_CYC
)(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic        clkEn,
   input wire logic        csN,
   input wire logic        sclk,
   input wire logic        si,
   input wire logic        soOut,
   input wire logic        soOe,
   input wire logic        rstN,
   input wire logic        serialOutputSupplyOk,
   input wire logic        battOverVoltage,
   input wire ssw_flt_t    chFault,
   input wire logic [15:0] lowSideSwitchOutputs,
   input wire ssw_cfg_t    cfgOut,
   input wire logic        ovShutdown
);
   // Cycles of unbroken over-voltage, saturating
   logic [15:0] ovCnt_r;
   always_ff @(posedge core_clk) begin
      if (srst || !battOverVoltage) begin
         ovCnt_r <= 16'h0000;
      end else if (ovCnt_r != 16'hFFFF) begin
         ovCnt_r <= ovCnt_r + 16'h0001;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_quiet;
      (!csN && !sclk) [*6];
   endsequence
   a_oe_idle: assert property (csN [*4] |-> !soOe)
      else $error("so driven while idle");
   a_oe_sel: assert property (!csN [*4] |-> soOe)
      else $error("so not driven");
   a_so_hold: assert property (s_quiet |-> $stable(soOut))
      else $error("so moved without rise");
   a_cfg_frame: assert property (!csN [*6] |-> $stable({cfgOut.olEn, cfgOut.sfpd, cfgOut.andOr}))
      else $error("config changed mid frame");
   a_ov_off: assert property (ovShutdown [*2] |-> lowSideSwitchOutputs == 16'h0000)
      else $error("driver on in shutdown");
   a_ov_trip: assert property (ovCnt_r == OV_FILT_CYC + 6 |-> ovShutdown)
      else $error("no shutdown");
   a_rst_clear: assert property (!rstN [*5] |-> lowSideSwitchOutputs == 16'h0000 && cfgOut.onOff == 16'h0000)
      else $error("reset did not clear");
   a_drv_cfg: assert property ($stable(cfgOut.onOff) [*2] |-> (lowSideSwitchOutputs & ~cfgOut.onOff) == 16'h0000)
      else $error("driver on while off");
endmodule

bind ssw_spi_ctrl ssw_spi_ctrl_chk #(.OV_FILT_CYC(OV_FILT_CYC)) u_chk (.core_clk(core_clk), .srst(srst),
   .clkEn(clkEn), .csN(csN), .sclk(sclk), .si(si), .soOut(soOut), .soOe(soOe), .rstN(rstN),
   .serialOutputSupplyOk(serialOutputSupplyOk), .battOverVoltage(battOverVoltage), .chFault(chFault),
   .lowSideSwitchOutputs(lowSideSwitchOutputs), .cfgOut(cfgOut), .ovShutdown(ovShutdown));

/* File: ssw_spi_master.sv */
// Serial master model framing transfers for the switch core.
// Assumes core_clk pacing; sclk half period is four core clocks.
`timescale 1ns/1ns
module ssw_spi_master (
   input  wire logic core_clk,
   input  wire logic soOut,
   input  wire logic soOe,
   output logic      csN,
   output logic      sclk,
   output logic      si
);
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   task automatic xfer(input logic [23:0] cmd, input int nb, output logic [23:0] rsp);
      rsp = 24'h00_0000;
      @(posedge core_clk);
      csN <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < nb; i++) begin
         si <= cmd[23 - (i % 24)];
         sclk <= 1'b1;
         repeat (4) @(posedge core_clk);
         sclk <= 1'b0;
         repeat (4) @(posedge core_clk);
         rsp = {rsp[22:0], soOe ? soOut : 1'bx};
      end
      csN <= 1'b1;
      si <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for ssw_spi_ctrl driven by the serial master model.
// Assumes the checker binds itself; over-voltage filter shortened to OVF.
`timescale 1ns/1ns
module testbench;
   import ssw_pkg::*;
   localparam int       OVF  = 20;
   localparam int       CW   = $bits(ssw_cfg_t);
   localparam ssw_cfg_t CRST = '{SSW_ONOFF_RST, SSW_OLEN_RST, SSW_SFPD_RST, SSW_PWMEN_RST, SSW_ANDOR_RST, 1'b0, 1'b0};
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        rstN     = 1'b1;
   logic        supOk    = 1'b1;
   logic        battOv   = 1'b0;
   ssw_flt_t    chFault  = '0;
   ssw_cfg_t    exp      = CRST;
   ssw_cfg_t    cfgOut;
   logic        csN, sclk, si, soOut, soOe, ovShutdown;
   logic [15:0] drv, o;
   logic [23:0] rsp, w;
   int          seed = 87, miscompares = 0, n_compared = 0, cyc = 0;
   ssw_spi_ctrl #(.OV_FILT_CYC(OVF)) u_dut (.core_clk(core_clk), .srst(srst), .clkEn(1'b1), .csN(csN),
      .sclk(sclk), .si(si), .soOut(soOut), .soOe(soOe), .rstN(rstN), .serialOutputSupplyOk(supOk),
      .battOverVoltage(battOv), .chFault(chFault), .lowSideSwitchOutputs(drv), .cfgOut(cfgOut),
      .ovShutdown(ovShutdown));
   ssw_spi_master u_mst (.core_clk(core_clk), .soOut(soOut), .soOe(soOe), .csN(csN), .sclk(sclk), .si(si));
   task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] want);
      n_compared++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   function automatic ssw_cfg_t upd(ssw_cfg_t c, logic [23:0] x);
      case (x[23:18])
         SSW_CMD_ONOFF: c.onOff = x[15:0];
         SSW_CMD_OLEN: c.olEn = x[15:0];
         SSW_CMD_RETRY: {c.thRetry, c.ovRetry} = x[17:16];
         SSW_CMD_SFPD: c.sfpd = x[15:0];
         SSW_CMD_PWMEN: c.pwmEn = x[15:0];
         SSW_CMD_ANDOR: c.andOr = x[15:0];
         SSW_CMD_RESET: c = CRST;
         default: ;
      endcase
      return c;
   endfunction
   task automatic send(input logic [23:0] x);
      u_mst.xfer(x, 24, rsp);
      exp = upd(exp, x);
   endtask
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(cfgOut, CRST);
      // Every selector once, then random ones including unknown codes
      for (int k = 0; k < 16; k++) begin
         w = {(k < 8) ? k[5:0] : 6'($random(seed) % 8), 18'($random(seed))};
         send(w);
         check(CW'(rsp), '0);
         check(cfgOut, exp);
         check(CW'(drv), CW'(exp.onOff));
      end
      $display("command test done");
      send({SSW_CMD_OLEN, 2'b00, 16'hFFFF});
      w = {SSW_CMD_ONOFF, 2'b00, 16'($random(seed))};
      send(w);
      o = 16'($random(seed));
      chFault.openLoad <= o;
      repeat (6) @(posedge core_clk);
      fork
         send({SSW_CMD_ONOFF, 2'b00, ~w[15:0]});
         begin
            repeat (40) @(posedge core_clk);
            chFault.openLoad <= ~o;
         end
      join
      o = o & ~w[15:0];
      check(CW'(rsp), CW'({|o, 7'h00, o}));
      chFault.openLoad <= 16'h0000;
      $display("open load test done");
      w = {SSW_CMD_ONOFF, 2'b00, 16'($random(seed))};
      u_mst.xfer(w, 48, rsp);
      check(CW'(rsp), CW'(w));
      u_mst.xfer(~w, 16, rsp);
      check(CW'(drv), CW'(w[15:0]));
      exp.onOff = w[15:0];
      $display("chain test done");
      for (int r = 1; r >= 0; r--) begin
         send({SSW_CMD_RETRY, 1'b0, r[0], 16'h0000});
         battOv <= 1'b1;
         repeat (OVF - 6) @(posedge core_clk);
         battOv <= 1'b0;
         repeat (10) @(posedge core_clk);
         check(CW'(ovShutdown), '0);
         battOv <= 1'b1;
         repeat (OVF + 12) @(posedge core_clk);
         check(CW'({ovShutdown, drv}), CW'(17'h1_0000));
         battOv <= 1'b0;
         repeat (10) @(posedge core_clk);
         if (!r[0]) exp.onOff = 16'h0000;
         check(cfgOut, exp);
         check(CW'(drv), CW'(exp.onOff));
         send({SSW_CMD_ONOFF, 2'b00, w[15:0]});
         check(CW'(rsp[23:22]), CW'(2'b11));
      end
      $display("over-voltage test done");
      for (int r = 0; r < 2; r++) begin
         send({SSW_CMD_RETRY, r[0], 17'h0_0000});
         send({SSW_CMD_ONOFF, 2'b00, 16'hFFFF});
         chFault.overTemp <= 16'h0008;
         repeat (10) @(posedge core_clk);
         check(CW'(drv), CW'(16'hFFF7));
         chFault.overTemp <= 16'h0000;
         repeat (10) @(posedge core_clk);
         check(CW'(drv), r ? CW'(16'hFFFF) : CW'(16'hFFF7));
         send({SSW_CMD_PWMEN, 18'h0_0000});
         check(CW'(rsp), r ? '0 : CW'(24'h80_0008));
      end
      // Over-current on a driven output must show in the fault word
      chFault.overCurrent <= 16'h0010;
      repeat (6) @(posedge core_clk);
      send({SSW_CMD_PWMEN, 18'h0_0000});
      check(CW'(rsp), CW'(24'h80_0010));
      chFault.overCurrent <= 16'h0000;
      $display("thermal test done");
      for (int p = 0; p < 2; p++) begin
         send({SSW_CMD_ONOFF, 2'b00, 16'hA5A5});
         if (p == 0) rstN <= 1'b0;
         else supOk <= 1'b0;
         repeat (6) @(posedge core_clk);
         check(CW'(drv), '0);
         check(cfgOut, CRST);
         rstN <= 1'b1;
         supOk <= 1'b1;
         repeat (6) @(posedge core_clk);
      end
      $display("reset pin test done");
      print_verdict();
   end
endmodule
